/* bench/mie_core_sva.sv */
// Port assertions for the instruction core.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module mie_core_sva #(
  parameter PC_W = 11  // Program address width
) (
  input wire            clk,       // Clock
  input wire            rst,       // Reset
  input wire [7:0]      dmAddr,    // Data address
  input wire            dmWe,      // Write strobe
  input wire            halted,    // Power-down
  input wire            wdtClear,  // Watchdog clear
  input wire [7:0]      acc,       // Accumulator
  input wire            carry,     // Carry flag
  input wire            zero,      // Zero flag
  input wire [PC_W-1:0] pc,        // Program counter
  input wire            iCycleEnd  // Cycle end pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_icycle_four: assert property (iCycleEnd |=> !iCycleEnd [*3])
    else $error("instruction cycle shorter than four clocks");
  chk_pc_at_end: assert property (!$stable(pc) |-> iCycleEnd)
    else $error("pc moved inside a cycle");
  chk_acc_at_end: assert property (!$stable(acc) |-> iCycleEnd)
    else $error("acc moved inside a cycle");
  chk_flags_at_end: assert property (!$stable({carry, zero}) |-> iCycleEnd)
    else $error("flags moved inside a cycle");
  chk_we_at_end: assert property (dmWe |-> iCycleEnd)
    else $error("write strobe off the cycle end");
  chk_we_single: assert property (dmWe |=> !dmWe [*3])
    else $error("write strobe repeated");
  chk_pcl_no_write: assert property (dmWe |-> dmAddr != 8'h02)
    else $error("low pc byte written to memory");
  chk_halt_frozen: assert property (halted && $past(halted) |-> $stable(pc) && !dmWe)
    else $error("core active while halted");
  chk_wdt_pulse: assert property (wdtClear |=> !wdtClear)
    else $error("watchdog clear longer than one clock");

  cover property (dmWe);
  cover property ($rose(halted));
  cover property (wdtClear);
endmodule // mie_core_sva

bind mie_core mie_core_sva #(.PC_W(PC_W)) chk (
  .clk(clk), .rst(rst), .dmAddr(dmAddr), .dmWe(dmWe), .halted(halted),
  .wdtClear(wdtClear), .acc(acc), .carry(carry), .zero(zero), .pc(pc),
  .iCycleEnd(iCycleEnd)
);

/* bench/mie_mem_model.sv */
// Program and data memories facing the core.
// Assumes registered reads with one clock of latency.
`timescale 1ns/1ps
module mie_mem_model #(
  parameter PC_W = 11  // Program address width
) (
  input  wire            clk,       // Clock
  input  wire [PC_W-1:0] pmAddr,    // Program address
  output reg  [15:0]     pmRdData,  // Program word
  input  wire [7:0]      dmAddr,    // Data address
  output reg  [7:0]      dmRdData,  // Data byte
  input  wire [7:0]      dmWrData,  // Write byte
  input  wire            dmWe       // Write strobe
);
  reg [15:0] pm [0:(1<<PC_W)-1];
  reg [7:0]  dm [0:255];
  // Old data on a same-clock read, as a plain synchronous RAM
  always @(posedge clk) begin
    pmRdData <= pm[pmAddr];
    dmRdData <= dm[dmAddr];
    if (dmWe) begin
      dm[dmAddr] <= dmWrData;
    end
  end
endmodule // mie_mem_model

/* bench/testbench.sv */
// Self-checking bench for the instruction core.
// Assumes the memory model and the checker bound to the core.
`timescale 1ns/1ps
`include "mie_consts.vh"
module testbench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         wake = 1'b0;
  wire [10:0] pmAddr, pc;
  wire [15:0] pmRdData;
  wire [7:0]  dmAddr, dmRdData, dmWrData, acc, tabHigh;
  wire        dmWe, halted, wdtClear, carry, zero, iCycleEnd;
  integer     badCount = 0, numChecks = 0, base, n, wdtSeen, i;

  always #10 clk = ~clk;
  always @(posedge clk) if (wdtClear === 1'b1) wdtSeen <= wdtSeen + 1;

  mie_core #(.PC_W(11), .SP_W(3)) DUT (
    .clk(clk), .rst(rst), .pmAddr(pmAddr), .pmRdData(pmRdData), .dmAddr(dmAddr),
    .dmRdData(dmRdData), .dmWrData(dmWrData), .dmWe(dmWe), .wake(wake),
    .halted(halted), .wdtClear(wdtClear), .acc(acc), .carry(carry), .zero(zero),
    .pc(pc), .tabHigh(tabHigh), .iCycleEnd(iCycleEnd));
  mie_mem_model #(.PC_W(11)) partner (
    .clk(clk), .pmAddr(pmAddr), .pmRdData(pmRdData), .dmAddr(dmAddr),
    .dmRdData(dmRdData), .dmWrData(dmWrData), .dmWe(dmWe));

  task endSim;
    begin
      if (badCount == 0 && numChecks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input [63:0] name, input [15:0] exp, input [15:0] got);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        badCount = badCount + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task p(input [10:0] a, input [4:0] op, input [10:0] arg);
    partner.pm[a] = {op, arg};
  endtask

  task clr;
    begin
      for (i = 0; i < 2048; i = i + 1) partner.pm[i] = 16'h0000;
      for (i = 0; i < 256; i = i + 1) partner.dm[i] = 8'h00;
    end
  endtask

  // Every wait is bounded; running out ends the run
  task waitHalt(input v);
    begin
      n = 0;
      while (halted !== v && n < 100) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n >= 100) begin
        chk("wait", 16'h0001, 16'h0000);
        endSim;
      end
    end
  endtask

  task run;
    begin
      @(posedge clk) rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wdtSeen = 0;
      @(posedge clk);
      #1;
      waitHalt(1'b1);
    end
  endtask

  task tBase;
    begin
      clr;
      p(0, `MIE_OP_HALT, 11'h000);
      run;
      base = n;
      chk("pc", 16'h0001, {5'h00, pc});
    end
  endtask

  task tFlow;
    begin
      clr;
      p(0, `MIE_OP_MOVAI, 11'h05a);
      p(1, `MIE_OP_JMP, 11'h003);
      p(2, `MIE_OP_MOVAI, 11'h000);
      p(3, `MIE_OP_CALL, 11'h006);
      p(4, `MIE_OP_HALT, 11'h000);
      p(6, `MIE_OP_RET, 11'h000);
      run;
      chk("clocks", base + 28, n);
      chk("acc", 16'h005a, {8'h00, acc});
      chk("pc", 16'h0005, {5'h00, pc});
    end
  endtask

  task tSkip;
    begin
      clr;
      partner.dm[8'h11] = 8'hfe;
      p(0, `MIE_OP_SZ, 11'h010);
      p(1, `MIE_OP_MOVAI, 11'h001);
      p(2, `MIE_OP_SBIT, 11'h011);
      p(3, `MIE_OP_MOVAI, 11'h007);
      p(4, `MIE_OP_HALT, 11'h000);
      run;
      chk("clocks", base + 16, n);
      chk("acc", 16'h0007, {8'h00, acc});
    end
  endtask

  task tArith;
    begin
      clr;
      partner.dm[8'h20] = 8'h7f;
      p(0, `MIE_OP_MOVAI, 11'h0ff);
      p(1, `MIE_OP_ADDI, 11'h001);
      p(2, `MIE_OP_SUBI, 11'h001);
      p(3, `MIE_OP_INC, 11'h120);
      p(4, `MIE_OP_DEC, 11'h020);
      p(5, `MIE_OP_HALT, 11'h000);
      run;
      chk("clocks", base + 20, n);
      chk("acc", 16'h007f, {8'h00, acc});
      chk("flags", 16'h0002, {14'h0000, carry, zero});
      chk("mem", 16'h0080, {8'h00, partner.dm[8'h20]});
    end
  endtask

  task tLogic;
    begin
      clr;
      partner.dm[8'h30] = 8'h0f;
      partner.dm[8'h31] = 8'h81;
      p(0, `MIE_OP_MOVAI, 11'h0f0);
      p(1, `MIE_OP_AND, 11'h030);
      p(2, `MIE_OP_RRC, 11'h131);
      p(3, `MIE_OP_RL, 11'h030);
      p(4, `MIE_OP_HALT, 11'h000);
      run;
      chk("acc", 16'h001e, {8'h00, acc});
      chk("flags", 16'h0003, {14'h0000, carry, zero});
      chk("mem", 16'h0040, {8'h00, partner.dm[8'h31]});
    end
  endtask

  task tMove;
    begin
      clr;
      partner.dm[8'h41] = 8'hff;
      p(0, `MIE_OP_MOVAI, 11'h055);
      p(1, `MIE_OP_MOVMA, 11'h042);
      p(2, `MIE_OP_MOVAI, 11'h000);
      p(3, `MIE_OP_MOVAM, 11'h042);
      p(4, `MIE_OP_BSET, 11'h340);
      p(5, `MIE_OP_BCLR, 11'h741);
      p(6, `MIE_OP_ADDI, 11'h0b4);
      p(7, `MIE_OP_MOVMA, 11'h002);
      p(8, `MIE_OP_MOVAI, 11'h0ee);
      p(9, `MIE_OP_HALT, 11'h000);
      run;
      chk("clocks", base + 36, n);
      chk("acc", 16'h0009, {8'h00, acc});
      chk("mem42", 16'h0055, {8'h00, partner.dm[8'h42]});
      chk("mem40", 16'h0008, {8'h00, partner.dm[8'h40]});
      chk("mem41", 16'h007f, {8'h00, partner.dm[8'h41]});
    end
  endtask

  task tMore;
    begin
      clr;
      partner.dm[8'h60] = 8'h0f;
      partner.dm[8'h61] = 8'h3c;
      p(0, `MIE_OP_MOVAI, 11'h081);
      p(1, `MIE_OP_OR, 11'h060);
      p(2, `MIE_OP_XOR, 11'h160);
      p(3, `MIE_OP_CPL, 11'h061);
      p(4, `MIE_OP_ADD, 11'h161);
      p(5, `MIE_OP_SUB, 11'h061);
      p(6, `MIE_OP_RLC, 11'h160);
      p(7, `MIE_OP_RR, 11'h060);
      p(8, `MIE_OP_CALL, 11'h00a);
      p(9, `MIE_OP_HALT, 11'h000);
      p(10, `MIE_OP_NOP, 11'h000);
      p(11, `MIE_OP_INTERRUPT_EXIT_OP, 11'h000);
      run;
      chk("clocks", base + 52, n);
      chk("acc", 16'h0080, {8'h00, acc});
      chk("flags", 16'h0002, {14'h0000, carry, zero});
      chk("mem60", 16'h0001, {8'h00, partner.dm[8'h60]});
      chk("mem61", 16'h00ff, {8'h00, partner.dm[8'h61]});
      chk("pc", 16'h000a, {5'h00, pc});
    end
  endtask

  task tTable;
    begin
      clr;
      partner.pm[11'h733] = 16'hbeef;
      p(0, `MIE_OP_MOVAI, 11'h033);
      p(1, `MIE_OP_TABRD, 11'h050);
      p(2, `MIE_OP_CLRWDT, 11'h000);
      p(3, `MIE_OP_HALT, 11'h000);
      p(4, `MIE_OP_MOVAI, 11'h077);
      p(5, `MIE_OP_HALT, 11'h000);
      run;
      chk("clocks", base + 16, n);
      chk("tabLow", 16'h00ef, {8'h00, partner.dm[8'h50]});
      chk("tabHigh", 16'h00be, {8'h00, tabHigh});
      chk("wdt", 16'h0001, wdtSeen);
      @(posedge clk) wake <= 1'b1;
      waitHalt(1'b0);
      @(posedge clk) wake <= 1'b0;
      waitHalt(1'b1);
      chk("acc", 16'h0077, {8'h00, acc});
    end
  endtask

  initial begin
    tBase;
    tFlow;
    tSkip;
    tArith;
    tLogic;
    tMove;
    tMore;
    tTable;
    endSim;
  end
endmodule // testbench

/* src/mie_alu.v */
// Combinational datapath of the core: arithmetic, logic, rotate, bit ops.
// Assumes operands are stable during the execute phase.
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_alu (
  input  wire [4:0] op,        // Opcode
  input  wire [7:0] acc,       // Accumulator
  input  wire [7:0] opnd,      // Data memory operand
  input  wire [7:0] imm,       // Immediate byte
  input  wire [2:0] bitSel,    // Bit index
  input  wire       carryIn,   // Carry flag
  output reg  [7:0] result,    // Result byte
  output reg        carryOut,  // New carry
  output reg        carryUpd,  // Carry is written
  output reg        zeroUpd    // Zero flag is written
);

  reg [8:0] wide;

  function [7:0] bitMask;
    input [2:0] idx;
    begin
      bitMask = 8'h01 << idx;
    end
  endfunction

  always @* begin
    wide     = 9'h000;
    result   = opnd;
    carryOut = carryIn;
    carryUpd = 1'b0;
    zeroUpd  = 1'b0;
    case (op)
      `MIE_OP_MOVAM: result = opnd;
      `MIE_OP_MOVMA: result = acc;
      `MIE_OP_MOVAI: result = imm;
      `MIE_OP_ADD, `MIE_OP_ADDI: begin
        wide     = {1'b0, acc} + {1'b0, (op == `MIE_OP_ADD) ? opnd : imm};
        result   = wide[7:0];
        carryOut = wide[8];
        carryUpd = 1'b1;
        zeroUpd  = 1'b1;
      end
      `MIE_OP_SUB, `MIE_OP_SUBI: begin
        wide     = {1'b0, acc} - {1'b0, (op == `MIE_OP_SUB) ? opnd : imm};
        result   = wide[7:0];
        carryOut = wide[8];
        carryUpd = 1'b1;
        zeroUpd  = 1'b1;
      end
      `MIE_OP_AND: begin
        result  = acc & opnd;
        zeroUpd = 1'b1;
      end
      `MIE_OP_OR: begin
        result  = acc | opnd;
        zeroUpd = 1'b1;
      end
      `MIE_OP_XOR: begin
        result  = acc ^ opnd;
        zeroUpd = 1'b1;
      end
      `MIE_OP_CPL: begin
        result  = ~opnd;
        zeroUpd = 1'b1;
      end
      `MIE_OP_INC: begin
        result  = opnd + 8'h01;
        zeroUpd = 1'b1;
      end
      `MIE_OP_DEC: begin
        result  = opnd - 8'h01;
        zeroUpd = 1'b1;
      end
      `MIE_OP_RR: result = {opnd[0], opnd[7:1]};
      `MIE_OP_RL: result = {opnd[6:0], opnd[7]};
      `MIE_OP_RRC: begin
        result   = {carryIn, opnd[7:1]};
        carryOut = opnd[0];
        carryUpd = 1'b1;
      end
      `MIE_OP_RLC: begin
        result   = {opnd[6:0], carryIn};
        carryOut = opnd[7];
        carryUpd = 1'b1;
      end
      `MIE_OP_BSET: result = opnd | bitMask(bitSel);
      `MIE_OP_BCLR: result = opnd & ~bitMask(bitSel);
      default:      result = opnd;
    endcase
  end

endmodule // mie_alu

/* src/mie_consts.vh */
// Constants for the instruction execution core: opcodes, timing, reset values.
// Assumes inclusion by the core, its ALU and the testbench; holds definitions only.
// Behaviour
// - Most instructions one cycle, branches take two
// - Instruction cycle spans four system clocks
// - Jump, call, returns, table read add cycle
// - Writing program_counter_low jumps, adds one cycle
// - Taken skip costs one extra cycle
// - Add carries above 255, subtract borrows below 0
// - Increment and decrement change value by one
// - Logic results of zero set zero flag
// - Logic operands pass through the accumulator
// - Rotates move operand exactly one bit
// - Rotate through carry puts outgoing bit in carry
// - Transfers: register, accumulator, immediate forms
// - Call saves return, return resumes after call
// - Conditional skip tests byte or single bit
// - Bit set and clear touch one bit
// - Table read fetches constant program-memory data
// - Power-down instruction halts; watchdog clear separate
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH

// Timing
`define MIE_CLKS_PER_ICYCLE 4
`define MIE_PH0             4'h1
`define MIE_PH1             4'h2
`define MIE_PH2             4'h4
`define MIE_PH3             4'h8

// Instruction word fields
`define MIE_OP_HI   15
`define MIE_OP_LO   11
`define MIE_DEST    8
`define MIE_BIT_HI  10
`define MIE_BIT_LO  8

// Opcodes
`define MIE_OP_NOP    5'h00
`define MIE_OP_MOVAM  5'h01
`define MIE_OP_MOVMA  5'h02
`define MIE_OP_MOVAI  5'h03
`define MIE_OP_ADD    5'h04
`define MIE_OP_ADDI   5'h05
`define MIE_OP_SUB    5'h06
`define MIE_OP_SUBI   5'h07
`define MIE_OP_AND    5'h08
`define MIE_OP_OR     5'h09
`define MIE_OP_XOR    5'h0a
`define MIE_OP_CPL    5'h0b
`define MIE_OP_INC    5'h0c
`define MIE_OP_DEC    5'h0d
`define MIE_OP_RR     5'h0e
`define MIE_OP_RL     5'h0f
`define MIE_OP_RRC    5'h10
`define MIE_OP_RLC    5'h11
`define MIE_OP_JMP    5'h12
`define MIE_OP_CALL   5'h13
`define MIE_OP_RET    5'h14
`define MIE_OP_INTERRUPT_EXIT_OP   5'h15
`define MIE_OP_SZ     5'h16
`define MIE_OP_SBIT   5'h17
`define MIE_OP_BSET   5'h18
`define MIE_OP_BCLR   5'h19
`define MIE_OP_TABRD  5'h1a
`define MIE_OP_HALT   5'h1b
`define MIE_OP_CLRWDT 5'h1c

// Data address that aliases the low program counter byte
`define MIE_PCL_ADDR  8'h02
// Upper program address bits of the constant table
`define MIE_TAB_PAGE  3'h7

// Reset values
`define MIE_RST_PC    11'h000
`define MIE_RST_BYTE  8'h00
`define MIE_RST_WORD  16'h0000

`endif

/* src/mie_core.v */
// Instruction sequencer of the 8-bit core: fetch, execute, flow control.
// Assumes program and data memories on the same clock with one-clock
// registered read latency.
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_core #(
  parameter PC_W = 11,   // Program address width
  parameter SP_W = 3     // Stack pointer width, depth 2**SP_W
) (
  input  wire            clk,       // System clock
  input  wire            rst,       // Synchronous reset, active high
  output reg  [PC_W-1:0] pmAddr,    // Program memory address
  input  wire [15:0]     pmRdData,  // Program memory read word
  output reg  [7:0]      dmAddr,    // Data memory address
  input  wire [7:0]      dmRdData,  // Data memory read byte
  output reg  [7:0]      dmWrData,  // Data memory write byte
  output reg             dmWe,      // Data memory write strobe
  input  wire            wake,      // Asynchronous wake-up request
  output reg             halted,    // Core in power-down
  output reg             wdtClear,  // Watchdog clear pulse
  output reg  [7:0]      acc,       // Accumulator
  output reg             carry,     // Carry flag
  output reg             zero,      // Zero flag
  output reg  [PC_W-1:0] pc,        // Program counter
  output reg  [7:0]      tabHigh,   // Upper byte of last table read
  output reg             iCycleEnd  // Pulse at end of each instruction cycle
);

  reg [3:0]      ph;
  reg [15:0]     ir;
  reg            extra;
  reg            tabPend;
  reg [15:0]     tabWord;
  reg [SP_W:0]   sp;
  reg [PC_W-1:0] stack [0:(1<<SP_W)-1];
  reg            wakeS1;
  reg            wakeS2;

  wire [4:0]      op     = ir[`MIE_OP_HI:`MIE_OP_LO];
  wire [7:0]      mAddr  = ir[7:0];
  wire [7:0]      opnd   = (mAddr == `MIE_PCL_ADDR) ? pc[7:0] : dmRdData;
  wire [PC_W-1:0] pcNext = pc + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pcSkip = pc + {{(PC_W-2){1'b0}}, 2'b10};
  wire [SP_W-1:0] spTop  = sp[SP_W-1:0] - {{(SP_W-1){1'b0}}, 1'b1};

  wire [7:0] aluRes;
  wire       aluCy;
  wire       cyUpd;
  wire       zUpd;

  mie_alu u_alu (
    .op       (op),
    .acc      (acc),
    .opnd     (opnd),
    .imm      (ir[7:0]),
    .bitSel   (ir[`MIE_BIT_HI:`MIE_BIT_LO]),
    .carryIn  (carry),
    .result   (aluRes),
    .carryOut (aluCy),
    .carryUpd (cyUpd),
    .zeroUpd  (zUpd)
  );

  // Destination decode
  reg toAcc;
  reg toMem;
  always @* begin
    toAcc = 1'b0;
    toMem = 1'b0;
    case (op)
      `MIE_OP_MOVAM, `MIE_OP_MOVAI, `MIE_OP_ADDI, `MIE_OP_SUBI:
        toAcc = 1'b1;
      `MIE_OP_MOVMA, `MIE_OP_BSET, `MIE_OP_BCLR:
        toMem = 1'b1;
      `MIE_OP_ADD, `MIE_OP_SUB, `MIE_OP_AND, `MIE_OP_OR, `MIE_OP_XOR,
      `MIE_OP_CPL, `MIE_OP_INC, `MIE_OP_DEC, `MIE_OP_RR, `MIE_OP_RL,
      `MIE_OP_RRC, `MIE_OP_RLC: begin
        toMem = ir[`MIE_DEST];
        toAcc = ~ir[`MIE_DEST];
      end
      default: begin
        toAcc = 1'b0;
        toMem = 1'b0;
      end
    endcase
  end

  // skip test on byte or bit
  reg skipTaken;
  always @* begin
    case (op)
      `MIE_OP_SZ:   skipTaken = (opnd == 8'h00);
      `MIE_OP_SBIT: skipTaken = opnd[ir[`MIE_BIT_HI:`MIE_BIT_LO]];
      default:      skipTaken = 1'b0;
    endcase
  end

  wire pclWrite = toMem && (mAddr == `MIE_PCL_ADDR);

  // Wake pin crosses in from outside
  always @(posedge clk) begin
    if (rst) begin
      wakeS1 <= 1'b0;
      wakeS2 <= 1'b0;
    end else begin
      wakeS1 <= wake;
      wakeS2 <= wakeS1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ph        <= `MIE_PH0;
      ir        <= `MIE_RST_WORD;
      extra     <= 1'b0;
      tabPend   <= 1'b0;
      tabWord   <= `MIE_RST_WORD;
      tabHigh   <= `MIE_RST_BYTE;
      sp        <= {(SP_W+1){1'b0}};
      pc        <= `MIE_RST_PC;
      pmAddr    <= `MIE_RST_PC;
      dmAddr    <= `MIE_RST_BYTE;
      dmWrData  <= `MIE_RST_BYTE;
      dmWe      <= 1'b0;
      acc       <= `MIE_RST_BYTE;
      carry     <= 1'b0;
      zero      <= 1'b0;
      halted    <= 1'b0;
      wdtClear  <= 1'b0;
      iCycleEnd <= 1'b0;
    end else begin
      dmWe      <= 1'b0;
      wdtClear  <= 1'b0;
      iCycleEnd <= 1'b0;
      if (halted) begin
        ph <= `MIE_PH0;
        if (wakeS2) begin
          halted <= 1'b0;
        end
      end else begin
        case (ph)
          `MIE_PH0: ph <= `MIE_PH1;
          `MIE_PH1: begin
            ph <= `MIE_PH2;
            if (tabPend) begin
              tabWord <= pmRdData;
            end else if (!extra) begin
              ir     <= pmRdData;
              dmAddr <= pmRdData[7:0];
            end
          end
          `MIE_PH2: ph <= `MIE_PH3;
          `MIE_PH3: begin
            ph        <= `MIE_PH0;
            iCycleEnd <= 1'b1;
            if (tabPend) begin
              tabPend  <= 1'b0;
              extra    <= 1'b0;
              dmWrData <= tabWord[7:0];
              dmWe     <= 1'b1;
              tabHigh  <= tabWord[15:8];
              pmAddr   <= pc;
            end else if (extra) begin
              extra <= 1'b0;
            end else begin
              pc     <= pcNext;
              pmAddr <= pcNext;
              if (toAcc) begin
                acc <= aluRes;
              end
              if (pclWrite) begin
                pc     <= {pc[PC_W-1:8], aluRes};
                pmAddr <= {pc[PC_W-1:8], aluRes};
                extra  <= 1'b1;
              end else if (toMem) begin
                dmWrData <= aluRes;
                dmWe     <= 1'b1;
              end
              if (cyUpd) begin
                carry <= aluCy;
              end
              if (zUpd) begin
                zero <= (aluRes == 8'h00);
              end
              case (op)
                `MIE_OP_JMP: begin
                  pc     <= ir[PC_W-1:0];
                  pmAddr <= ir[PC_W-1:0];
                  extra  <= 1'b1;
                end
                `MIE_OP_CALL: begin
                  stack[sp[SP_W-1:0]] <= pcNext;
                  sp     <= sp + {{SP_W{1'b0}}, 1'b1};
                  pc     <= ir[PC_W-1:0];
                  pmAddr <= ir[PC_W-1:0];
                  extra  <= 1'b1;
                end
                `MIE_OP_RET, `MIE_OP_INTERRUPT_EXIT_OP: begin
                  sp     <= sp - {{SP_W{1'b0}}, 1'b1};
                  pc     <= stack[spTop];
                  pmAddr <= stack[spTop];
                  extra  <= 1'b1;
                end
                `MIE_OP_SZ, `MIE_OP_SBIT: begin
                  if (skipTaken) begin
                    pc     <= pcSkip;
                    pmAddr <= pcSkip;
                    extra  <= 1'b1;
                  end
                end
                `MIE_OP_TABRD: begin
                  tabPend <= 1'b1;
                  pmAddr  <= {`MIE_TAB_PAGE, acc};
                end
                `MIE_OP_HALT: halted <= 1'b1;
                `MIE_OP_CLRWDT: wdtClear <= 1'b1;
                default: ;
              endcase
            end
          end
          default: ph <= `MIE_PH0;
        endcase
      end
    end
  end

endmodule // mie_core
